// ===== verilog/i2c_ctl_map.svh
`ifndef I2C_CTL_MAP_SVH
`define I2C_CTL_MAP_SVH

// ********************************
// bus framing
// ********************************
`define DEV_ADDR_BYTE 8'hDE
`define LAST_BIT      3'h7
`define CNT_ZERO      3'h0
`define SYNC_RESET    1'b1

// ********************************
// data byte layout
// ********************************
`define REG_SEL_BIT   7
`define PD_BIT        0
`define MUTE_BIT      1
`define DIAG_BIT      4
`define GAIN_HI       5
`define GAIN_LO       0

`endif

// ===== verilog/ctl_pkg.sv
`default_nettype none

package ctl_pkg;

    // ********************************
    // protocol states
    // ********************************
    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_ADDR     = 6'h02,
        ST_ADDR_ACK = 6'h04,
        ST_DATA     = 6'h08,
        ST_DATA_ACK = 6'h10,
        ST_IGNORE   = 6'h20
    } link_state_t;

    // ********************************
    // control outputs
    // ********************************
    typedef struct packed {
        logic       power_down_ctl;
        logic       mute_ctl;
        logic       diagnostic_select;
        logic [5:0] gain_step_field;
    } ctl_t;

    // ********************************
    // bus events in the clock domain
    // ********************************
    typedef struct packed {
        logic start;
        logic stop;
        logic fall;
        logic sample;
    } bus_evt_t;

endpackage : ctl_pkg

`default_nettype wire

// ===== verilog/sync2.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctl_map.svh"

module sync2 (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic d,
    output var  logic q
);

    logic meta;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= `SYNC_RESET;
            q    <= `SYNC_RESET;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : sync2

`default_nettype wire

// ===== verilog/bit_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module bit_sampler (
    input  wire logic scl,
    input  wire logic sda_i,
    output var  logic bit_val
);

    // ********************************
    // link domain: capture on scl rise
    // ********************************
    // no reset: read only after an scl rise has loaded it
    always_ff @(posedge scl) begin
        bit_val <= sda_i; // [RULE10]
    end

endmodule : bit_sampler

`default_nettype wire

// ===== verilog/write_only_serial_control_slave.sv
// Behaviour
// [RULE1] slave only, scl input, sda open-drain low
// [RULE2] master keeps scl at 400 kHz or less
// [RULE3] master holds sda stable while scl high
// [RULE4] transactions open with start, close with stop
// [RULE5] eight-bit words, each followed by ack slot
// [RULE6] start is sda falling while scl high
// [RULE7] master sends address msb first, then rw
// [RULE8] answer only address byte 11011110
// [RULE9] rw one: no ack, sda released
// [RULE10] address bits sampled on scl rise
// [RULE11] matching address acked low in ninth pulse
// [RULE12] master then sends data byte msb first
// [RULE13] top bit picks mode or volume register
// [RULE14] each data byte acked in next slot
// [RULE15] any number of data bytes until stop
// [RULE16] sda rising while scl high is stop
// [RULE17] after stop ignore bus until addressed
// [RULE18] reserved payload bits are discarded
// [RULE19] mode payload bit four selects test mode
// [RULE20] update on full byte, pin reset clears
// [RULE21] start or stop mid-byte drops byte
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctl_map.svh"

module write_only_serial_control_slave
    import ctl_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic scl,
    input  wire logic sda_i,
    output var  logic sda_o,
    output var  logic sda_oe,
    input  wire logic reset_pin_n,
    output var  ctl_t ctl,
    output var  logic addressed
);

    // ********************************
    // link domain and synchronisers
    // ********************************
    logic        bit_val;
    logic [3:0]  raw_in;
    logic [3:0]  syn;
    logic        scl_s;
    logic        sda_s;
    logic        bit_s;
    logic        pin_n_s;

    bit_sampler u_sampler (
        .scl     (scl),
        .sda_i   (sda_i),
        .bit_val (bit_val)
    );

    assign raw_in = {reset_pin_n, bit_val, sda_i, scl};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            sync2 u_sync (
                .clock (clock),
                .rst   (rst),
                .d     (raw_in[g]),
                .q     (syn[g])
            );
        end
    endgenerate

    assign scl_s   = syn[0];
    assign sda_s   = syn[1];
    assign bit_s   = syn[2];
    assign pin_n_s = syn[3];

    // ********************************
    // event detection
    // ********************************
    logic        scl_q;
    logic        sda_q;
    logic        rise_q;
    bus_evt_t    evt;

    always_ff @(posedge clock) begin
        if (rst) begin
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            rise_q <= 1'b0;
        end else begin
            scl_q  <= scl_s;
            sda_q  <= sda_s;
            // bit_s settles a cycle after scl_s rises
            rise_q <= scl_s & ~scl_q;
        end
    end

    always_comb begin
        evt.start  = scl_s & scl_q & sda_q & ~sda_s; // [RULE6]
        evt.stop   = scl_s & scl_q & ~sda_q & sda_s; // [RULE16]
        evt.fall   = ~scl_s & scl_q;
        evt.sample = rise_q; // [RULE10]
    end

    // ********************************
    // protocol state machine
    // ********************************
    link_state_t state;
    link_state_t next_state;
    logic [2:0]  cnt;
    logic [6:0]  shift;
    logic [7:0]  byte_w;
    logic        last;
    logic        addr_hit;
    logic        ack_end;
    logic        commit;

    assign byte_w   = {shift, bit_s};
    assign last     = evt.sample && (cnt == `LAST_BIT); // [RULE5]
    // rw bit is part of the compare, so reads never match
    assign addr_hit = (byte_w == `DEV_ADDR_BYTE); // [RULE8] [RULE9]
    assign ack_end  = evt.fall & sda_oe;
    assign commit   = (state == ST_DATA) & last; // [RULE20]

    always_comb begin
        next_state = state;
        if (evt.start) begin
            next_state = ST_ADDR; // [RULE4] [RULE21]
        end else if (evt.stop) begin
            next_state = ST_IDLE; // [RULE16] [RULE21]
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE; // [RULE17]
                end
                ST_ADDR: begin
                    if (last) begin
                        next_state = addr_hit ? ST_ADDR_ACK
                                              : ST_IGNORE; // [RULE9]
                    end
                end
                ST_ADDR_ACK: begin
                    if (ack_end) begin
                        next_state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (last) begin
                        next_state = ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    if (ack_end) begin
                        next_state = ST_DATA; // [RULE15]
                    end
                end
                ST_IGNORE: begin
                    next_state = ST_IGNORE; // [RULE17]
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ********************************
    // bit counter and shifter
    // ********************************
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt   <= `CNT_ZERO;
            shift <= 7'h00;
        end else if (evt.start || evt.stop) begin
            cnt   <= `CNT_ZERO; // [RULE21]
        end else if (evt.sample &&
                     (state == ST_ADDR || state == ST_DATA)) begin
            cnt   <= cnt + 3'h1;
            shift <= byte_w[6:0];
        end
    end

    // ********************************
    // acknowledge drive
    // ********************************
    always_ff @(posedge clock) begin
        if (rst) begin
            sda_oe <= 1'b0;
        end else if (evt.start || evt.stop || ack_end) begin
            sda_oe <= 1'b0;
        end else if (evt.fall && (state == ST_ADDR_ACK ||
                                  state == ST_DATA_ACK)) begin
            sda_oe <= 1'b1; // [RULE11] [RULE14]
        end
    end

    // only ever pulls low; scl is never driven
    always_ff @(posedge clock) begin
        sda_o <= 1'b0; // [RULE1]
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            addressed <= 1'b0;
        end else begin
            addressed <= (next_state == ST_ADDR_ACK) ||
                         (next_state == ST_DATA) ||
                         (next_state == ST_DATA_ACK);
        end
    end

    // ********************************
    // control registers
    // ********************************
    always_ff @(posedge clock) begin
        if (rst || !pin_n_s) begin
            ctl <= '0; // [RULE20]
        end else if (commit) begin
            if (byte_w[`REG_SEL_BIT]) begin // [RULE13]
                ctl.gain_step_field <=
                    byte_w[`GAIN_HI:`GAIN_LO]; // [RULE18]
            end else begin
                ctl.power_down_ctl    <= byte_w[`PD_BIT];
                ctl.mute_ctl          <= byte_w[`MUTE_BIT];
                ctl.diagnostic_select <= byte_w[`DIAG_BIT]; // [RULE19]
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_sda_low_only: assert property ( // [RULE1]
        sda_oe |-> (sda_o == 1'b0) &&
                   (state == ST_ADDR_ACK || state == ST_DATA_ACK)
    ) else $error("sda driven outside an ack slot");

    chk_start_to_addr: assert property ( // [RULE6]
        evt.start |=> (state == ST_ADDR) && (cnt == `CNT_ZERO)
                      && !sda_oe
    ) else $error("start did not restart address phase");

    chk_stop_to_idle: assert property ( // [RULE16]
        evt.stop |=> (state == ST_IDLE) && !sda_oe
    ) else $error("stop did not return to idle");

    chk_eight_bit_word: assert property ( // [RULE5]
        (state == ST_ADDR && evt.sample && cnt != `LAST_BIT
         && !evt.start && !evt.stop)
        |=> (state == ST_ADDR)
    ) else $error("address phase left before eighth bit");

    chk_read_refused: assert property ( // [RULE9]
        (state == ST_ADDR && last && bit_s && !evt.start
         && !evt.stop)
        |=> (state == ST_IGNORE) ##1 !sda_oe
    ) else $error("read address was not refused");

    chk_ignore_quiet: assert property ( // [RULE17]
        (state == ST_IGNORE && !evt.start)
        |=> (state == ST_IGNORE || state == ST_IDLE) && !sda_oe
    ) else $error("bus activity answered while ignored");

    chk_addr_ack_hold: assert property ( // [RULE11]
        (state == ST_ADDR_ACK && evt.fall && !sda_oe)
        |=> sda_oe ##1 sda_oe ##1 sda_oe
    ) else $error("address ack not driven");

    chk_data_ack: assert property ( // [RULE14]
        (state == ST_DATA_ACK && evt.fall && !sda_oe)
        |=> sda_oe && (state == ST_DATA_ACK)
    ) else $error("data ack not driven");

    chk_next_byte: assert property ( // [RULE15]
        (state == ST_DATA_ACK && ack_end && !evt.start)
        |=> (state == ST_DATA) && !sda_oe && (cnt == `CNT_ZERO)
    ) else $error("not ready for following data byte");

    chk_mode_write: assert property ( // [RULE13]
        (commit && pin_n_s && !byte_w[`REG_SEL_BIT])
        |=> (ctl.power_down_ctl == $past(byte_w[`PD_BIT]))
            && (ctl.mute_ctl == $past(byte_w[`MUTE_BIT]))
            && (ctl.diagnostic_select == $past(byte_w[`DIAG_BIT]))
            && $stable(ctl.gain_step_field)
    ) else $error("mode byte not stored correctly");

    chk_volume_write: assert property ( // [RULE18]
        (commit && pin_n_s && byte_w[`REG_SEL_BIT])
        |=> (ctl.gain_step_field == $past(byte_w[`GAIN_HI:`GAIN_LO]))
            && $stable(ctl.power_down_ctl) && $stable(ctl.mute_ctl)
    ) else $error("volume byte not stored correctly");

    chk_full_byte_only: assert property ( // [RULE21]
        (!commit && pin_n_s) |=> $stable(ctl)
    ) else $error("control changed without a full byte");

    chk_pin_reset: assert property ( // [RULE20]
        !pin_n_s |=> (ctl == '0)
    ) else $error("pin reset did not clear controls");

    chk_data_byte_end: assert property ( // [RULE5]
        (state == ST_DATA && last && !evt.start && !evt.stop)
        |=> (state == ST_DATA_ACK) && (cnt == `CNT_ZERO)
    ) else $error("data phase did not end after eighth bit");

    chk_idle_quiet: assert property ( // [RULE17]
        (state == ST_IDLE && !evt.start)
        |=> (state == ST_IDLE) && !sda_oe && !addressed
    ) else $error("idle bus answered without a start");

    chk_addressed_flag: assert property ( // [RULE8]
        addressed == (state == ST_ADDR_ACK || state == ST_DATA
                      || state == ST_DATA_ACK)
    ) else $error("addressed flag out of step with state");

    cov_single_write: cover property (
        (state == ST_DATA_ACK) ##[1:1000] evt.stop
    );

    cov_read_refused: cover property (
        (state == ST_ADDR) ##1 (state == ST_IGNORE)
    );

    cov_multi_byte: cover property (
        (state == ST_DATA_ACK && ack_end) ##[1:1000]
        (state == ST_DATA_ACK)
    );

    cov_repeated_start: cover property (
        (state == ST_DATA) && evt.start
    );

endmodule : write_only_serial_control_slave

`default_nettype wire

// ===== bench/serial_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
    input  wire logic clock,
    output var  logic scl,
    output var  logic sda_low,
    input  wire logic sda
);
    // ********
    // bus master
    // ********
    // phases of 80/160 clocks give a 2560 ns scl period
    localparam int Q = 80;
    localparam int H = 160;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clock);
    endtask : pause

    task automatic start_cond;
        pause(Q);
        sda_low <= 1'b0;
        pause(Q);
        scl <= 1'b1;
        pause(H);
        sda_low <= 1'b1;
        pause(H);
        scl <= 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        pause(Q);
        sda_low <= 1'b1;
        pause(Q);
        scl <= 1'b1;
        pause(H);
        sda_low <= 1'b0;
        pause(H);
    endtask : stop_cond

    // data changes only while scl is low
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            pause(Q);
            sda_low <= ~b[7-i];
            pause(Q);
            scl <= 1'b1;
            pause(H);
            scl <= 1'b0;
        end
    endtask : send_bits

    task automatic send_byte(input logic [7:0] b, output logic ack);
        send_bits(b, 8);
        pause(Q);
        sda_low <= 1'b0;
        pause(Q);
        scl <= 1'b1;
        pause(Q);
        ack = (sda === 1'b0);
        pause(Q);
        scl <= 1'b0;
    endtask : send_byte
endmodule : serial_master_model

`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import ctl_pkg::*;
;

    logic      clock;
    logic      rst;
    logic      reset_pin_n;
    logic      scl;
    logic      sda_low;
    logic      sda_o;
    logic      sda_oe;
    logic      addressed;
    logic      ack;
    logic[7:0] b;
    wire logic sda;
    ctl_t      ctl;
    ctl_t      model;
    int        mismatches;
    int        checks_done;
    integer    seed;

    // open-drain wire with pull-up
    assign sda = ~(sda_low | (sda_oe & ~sda_o));

    write_only_serial_control_slave u_write_only_serial_control_slave (
        .clock(clock), .rst(rst), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .reset_pin_n(reset_pin_n),
        .ctl(ctl), .addressed(addressed));

    serial_master_model u_serial_master_model (
        .clock(clock), .scl(scl), .sda_low(sda_low), .sda(sda));

    // ********
    // checking
    // ********
    function automatic ctl_t apply(input ctl_t c, input logic [7:0] d);
        if (d[7]) begin
            c.gain_step_field = d[5:0];
        end else begin
            c.power_down_ctl    = d[0];
            c.mute_ctl          = d[1];
            c.diagnostic_select = d[4];
        end
        return c;
    endfunction : apply

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: bit %b not %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_ctl(input ctl_t exp);
        checks_done++;
        if (ctl !== exp) begin
            mismatches++;
            $display("unexpected at %0t: ctl %h not %h", $time, ctl, exp);
        end
    endtask : check_ctl

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // whole transaction: address, first byte, n-1 random bytes
    task automatic xfer(input logic [7:0] a, input logic [7:0] first,
                        input int n, input logic ok);
        u_serial_master_model.start_cond();
        u_serial_master_model.send_byte(a, ack);
        check_bit(ack, ok);
        check_bit(addressed, ok);
        b = first;
        for (int i = 0; i < n; i++) begin
            u_serial_master_model.send_byte(b, ack);
            check_bit(ack, ok);
            if (ok) model = apply(model, b);
            b = 8'($random(seed));
        end
        u_serial_master_model.stop_cond();
        check_ctl(model);
        check_bit(addressed, 1'b0);
        $display("test xfer %h done", a);
    endtask : xfer

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        repeat (90000) @(posedge clock);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rst         = 1'b1;
        reset_pin_n = 1'b1;
        seed        = 32'hd7d2;
        model       = '0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (5) @(posedge clock);
        check_ctl(model);
        xfer(8'hDE, 8'hFF, 1, 1'b1);
        xfer(8'hDE, 8'h13, 3, 1'b1);
        xfer(8'hDE, 8'h40, 3, 1'b1);
        xfer(8'hDF, 8'hBF, 2, 1'b0);
        b = 8'($random(seed));
        if (b == 8'hDE) b = 8'h5E;
        xfer(b, 8'h80, 1, 1'b0);
        // bytes with no start are ignored
        u_serial_master_model.send_byte(8'h81, ack);
        check_bit(ack, 1'b0);
        check_ctl(model);
        $display("test idle bus done");
        // byte cut by repeated start, then by stop
        u_serial_master_model.start_cond();
        u_serial_master_model.send_byte(8'hDE, ack);
        u_serial_master_model.send_bits(8'h9A, 5);
        u_serial_master_model.start_cond();
        u_serial_master_model.send_byte(8'hDE, ack);
        check_bit(ack, 1'b1);
        check_ctl(model);
        u_serial_master_model.send_byte(8'h03, ack);
        model = apply(model, 8'h03);
        u_serial_master_model.send_bits(8'hBF, 6);
        u_serial_master_model.stop_cond();
        check_ctl(model);
        $display("test abort done");
        reset_pin_n <= 1'b0;
        repeat (10) @(posedge clock);
        check_ctl('0);
        reset_pin_n <= 1'b1;
        model = '0;
        $display("test pin reset done");
        xfer(8'hDE, 8'h2A, 2, 1'b1);
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
